/* File: rtl/slm_cfg_if.sv */
`timescale 1ns/100ps
interface slm_cfg_if;
   logic [11:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic rvalid;

   modport dev (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
   modport prog (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
endinterface : slm_cfg_if

/* File: rtl/slm_dev.sv */
`timescale 1ns/100ps
module slm_dev (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   slm_cfg_if.dev bus,
   // decoded link settings
   output logic descramble_en,
   output logic [5:0] lane_count,
   output logic [8:0] octets_per_frame,
   output logic [5:0] frames_per_mf,
   output logic [8:0] converter_count,
   output logic [2:0] subclass,
   output logic [5:0] samples_per_conv,
   output logic high_density,
   output logic [7:0] deskew_mask,
   output logic [7:0] lane_enable,
   output logic dual_link_select,
   // configuration check
   output logic cfg_check
);
   logic [7:0] cfg_q [slm_pkg::NUM_CFG];
   logic [7:0] cfg_d [slm_pkg::NUM_CFG];
   logic dual_q, dual_d;
   logic [7:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic [7:0] status_q, status_d;
   logic [3:0] idx;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic logic [3:0] cfg_index(input logic [11:0] a);
      case (a)
         slm_pkg::ADDR_LANE: return slm_pkg::IDX_LANE;
         slm_pkg::ADDR_OCTETS: return slm_pkg::IDX_OCTETS;
         slm_pkg::ADDR_FRAMES_MF: return slm_pkg::IDX_FRAMES_MF;
         slm_pkg::ADDR_CONV: return slm_pkg::IDX_CONV;
         slm_pkg::ADDR_RES: return slm_pkg::IDX_RES;
         slm_pkg::ADDR_SUBCLASS: return slm_pkg::IDX_SUBCLASS;
         slm_pkg::ADDR_VERSION: return slm_pkg::IDX_VERSION;
         slm_pkg::ADDR_DENSITY: return slm_pkg::IDX_DENSITY;
         slm_pkg::ADDR_DESKEW: return slm_pkg::IDX_DESKEW;
         slm_pkg::ADDR_OCTETS_DIRECT: return slm_pkg::IDX_OCTETS_DIRECT;
         slm_pkg::ADDR_LANE_EN: return slm_pkg::IDX_LANE_EN;
         default: return slm_pkg::IDX_NONE;
      endcase
   endfunction : cfg_index

   // ----------------------------------------
   // register bank access
   // ----------------------------------------
   // a read in the same cycle as a write returns the old value
   always_comb begin
      idx = cfg_index(bus.addr);
      for (int i = 0; i < slm_pkg::NUM_CFG; i++) begin
         cfg_d[i] = cfg_q[i];
      end
      dual_d = dual_q;
      rvalid_d = bus.rd;
      rdata_d = 8'h00;
      if (bus.wr) begin
         if (idx != slm_pkg::IDX_NONE) begin
            cfg_d[idx] = bus.wdata;
         end else if (bus.addr == slm_pkg::ADDR_LINK_CTRL) begin
            dual_d = bus.wdata[slm_pkg::DUAL_LINK_BIT];
         end
      end
      // unmapped reads return zero; the status register ignores writes
      if (bus.rd) begin
         if (idx != slm_pkg::IDX_NONE) begin
            rdata_d = cfg_q[idx];
         end else if (bus.addr == slm_pkg::ADDR_LINK_CTRL) begin
            rdata_d = 8'h00;
            rdata_d[slm_pkg::DUAL_LINK_BIT] = dual_q;
         end else if (bus.addr == slm_pkg::ADDR_STATUS) begin
            rdata_d = status_q;
         end
      end
   end

   // ----------------------------------------
   // configuration check
   // ----------------------------------------
   logic [25:0] lmfs;
   logic legal, single_only, lmfs_bad;
   always_comb begin
      lmfs = {cfg_q[slm_pkg::IDX_LANE][4:0], cfg_q[slm_pkg::IDX_OCTETS],
              cfg_q[slm_pkg::IDX_CONV], cfg_q[slm_pkg::IDX_VERSION][4:0]};
      legal = 1'b0;
      single_only = 1'b0;
      for (int i = 0; i < slm_pkg::NUM_LEGAL; i++) begin
         if (lmfs == slm_pkg::LEGAL_LMFS[i]) begin
            legal = 1'b1;
            single_only = (i < slm_pkg::NUM_SINGLE_ONLY);
         end
      end
      // direct count must equal octets field plus one
      lmfs_bad = !legal || (cfg_q[slm_pkg::IDX_OCTETS_DIRECT] != 8'(cfg_q[slm_pkg::IDX_OCTETS] + 8'h01));
      if (dual_q && single_only) begin
         lmfs_bad = 1'b1;
      end
      status_d = 8'h00;
      status_d[slm_pkg::STATUS_LMFS_BIT] = lmfs_bad;
      status_d[slm_pkg::STATUS_K_BIT] = (cfg_q[slm_pkg::IDX_FRAMES_MF][4:0] != slm_pkg::FRAMES_16) &&
                                        (cfg_q[slm_pkg::IDX_FRAMES_MF][4:0] != slm_pkg::FRAMES_32);
      status_d[slm_pkg::STATUS_SUBCLASS_BIT] = cfg_q[slm_pkg::IDX_SUBCLASS][7:5] > slm_pkg::SUBCLASS_1;
   end

   // ----------------------------------------
   // decoded settings, one cycle behind the bank
   // ----------------------------------------
   logic descr_d, hd_d;
   logic [5:0] lanes_d, frames_d, samples_d;
   logic [8:0] octets_d, conv_d;
   always_comb begin
      descr_d = cfg_q[slm_pkg::IDX_LANE][slm_pkg::SCRAMBLE_BIT];
      lanes_d = 6'(cfg_q[slm_pkg::IDX_LANE][4:0]) + 6'h01;
      octets_d = 9'(cfg_q[slm_pkg::IDX_OCTETS]) + 9'h001;
      frames_d = 6'(cfg_q[slm_pkg::IDX_FRAMES_MF][4:0]) + 6'h01;
      conv_d = 9'(cfg_q[slm_pkg::IDX_CONV]) + 9'h001;
      samples_d = 6'(cfg_q[slm_pkg::IDX_VERSION][4:0]) + 6'h01;
      hd_d = cfg_q[slm_pkg::IDX_DENSITY][slm_pkg::DENSITY_BIT];
   end

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < slm_pkg::NUM_CFG; i++) begin
            cfg_q[i] <= slm_pkg::CFG_RESET;
         end
         dual_q <= 1'b0;
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
         status_q <= 8'h00;
         descramble_en <= 1'b0;
         lane_count <= 6'h00;
         octets_per_frame <= 9'h000;
         frames_per_mf <= 6'h00;
         converter_count <= 9'h000;
         subclass <= 3'h0;
         samples_per_conv <= 6'h00;
         high_density <= 1'b0;
         deskew_mask <= 8'h00;
         lane_enable <= 8'h00;
         dual_link_select <= 1'b0;
         cfg_check <= 1'b0;
      end else begin
         for (int i = 0; i < slm_pkg::NUM_CFG; i++) begin
            cfg_q[i] <= cfg_d[i];
         end
         dual_q <= dual_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         status_q <= status_d;
         descramble_en <= descr_d;
         lane_count <= lanes_d;
         octets_per_frame <= octets_d;
         frames_per_mf <= frames_d;
         converter_count <= conv_d;
         subclass <= cfg_q[slm_pkg::IDX_SUBCLASS][7:5];
         samples_per_conv <= samples_d;
         high_density <= hd_d;
         deskew_mask <= cfg_q[slm_pkg::IDX_DESKEW];
         lane_enable <= cfg_q[slm_pkg::IDX_LANE_EN];
         dual_link_select <= dual_q;
         cfg_check <= status_q[slm_pkg::STATUS_LMFS_BIT];
      end
   end

   assign bus.rdata = rdata_q;
   assign bus.rvalid = rvalid_q;
endmodule : slm_dev

/* File: rtl/slm_pkg.sv */
package slm_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [11:0] ADDR_STATUS = 12'h030;
   localparam logic [11:0] ADDR_LINK_CTRL = 12'h300;
   localparam logic [11:0] ADDR_LANE = 12'h453;
   localparam logic [11:0] ADDR_OCTETS = 12'h454;
   localparam logic [11:0] ADDR_FRAMES_MF = 12'h455;
   localparam logic [11:0] ADDR_CONV = 12'h456;
   localparam logic [11:0] ADDR_RES = 12'h457;
   localparam logic [11:0] ADDR_SUBCLASS = 12'h458;
   localparam logic [11:0] ADDR_VERSION = 12'h459;
   localparam logic [11:0] ADDR_DENSITY = 12'h45a;
   localparam logic [11:0] ADDR_DESKEW = 12'h46c;
   localparam logic [11:0] ADDR_OCTETS_DIRECT = 12'h476;
   localparam logic [11:0] ADDR_LANE_EN = 12'h47d;

   // ----------------------------------------
   // index of each config register in the bank
   // ----------------------------------------
   localparam int NUM_CFG = 11;
   localparam logic [3:0] IDX_LANE = 4'h0;
   localparam logic [3:0] IDX_OCTETS = 4'h1;
   localparam logic [3:0] IDX_FRAMES_MF = 4'h2;
   localparam logic [3:0] IDX_CONV = 4'h3;
   localparam logic [3:0] IDX_RES = 4'h4;
   localparam logic [3:0] IDX_SUBCLASS = 4'h5;
   localparam logic [3:0] IDX_VERSION = 4'h6;
   localparam logic [3:0] IDX_DENSITY = 4'h7;
   localparam logic [3:0] IDX_DESKEW = 4'h8;
   localparam logic [3:0] IDX_OCTETS_DIRECT = 4'h9;
   localparam logic [3:0] IDX_LANE_EN = 4'ha;
   localparam logic [3:0] IDX_NONE = 4'hf;

   // ----------------------------------------
   // field positions and values
   // ----------------------------------------
   localparam int SCRAMBLE_BIT = 7;
   localparam int DENSITY_BIT = 7;
   localparam int DUAL_LINK_BIT = 3;
   localparam int STATUS_LMFS_BIT = 3;
   localparam int STATUS_K_BIT = 2;
   localparam int STATUS_SUBCLASS_BIT = 1;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [4:0] FRAMES_16 = 5'h0f;
   localparam logic [4:0] FRAMES_32 = 5'h1f;
   localparam logic [7:0] RES_VALUE = 8'h0f;
   localparam logic [4:0] SAMPLE_WIDTH_16 = 5'h0f;
   localparam logic [2:0] SUBCLASS_0 = 3'h0;
   localparam logic [2:0] SUBCLASS_1 = 3'h1;
   localparam logic [2:0] VERSION_B = 3'h1;
   localparam logic [3:0] PROG_LAST_STEP = 4'hb;

   // ----------------------------------------
   // per-mode settings, counts stored minus one
   // ----------------------------------------
   typedef struct packed {
      logic [4:0] lanes_m1;
      logic [7:0] octets_m1;
      logic [7:0] conv_m1;
      logic [4:0] samples_m1;
      logic high_density;
      logic [7:0] lane_mask;
   } slm_mode_t;

   localparam slm_mode_t MODE2 = '{5'h03, 8'h01, 8'h03, 5'h00, 1'b0, 8'h0f};
   localparam slm_mode_t MODE3 = '{5'h01, 8'h03, 8'h03, 5'h00, 1'b0, 8'h03};
   localparam slm_mode_t MODE4 = '{5'h03, 8'h00, 8'h01, 5'h00, 1'b1, 8'h0f};
   localparam slm_mode_t MODE5 = '{5'h03, 8'h01, 8'h01, 5'h01, 1'b0, 8'h0f};

   // supported {lanes, octets, converters, samples}; first four cannot run dual link
   localparam int NUM_LEGAL = 9;
   localparam int NUM_SINGLE_ONLY = 4;
   localparam logic [25:0] LEGAL_LMFS [NUM_LEGAL] = '{
      {5'h07, 8'h00, 8'h03, 5'h00}, {5'h07, 8'h01, 8'h03, 5'h01},
      {5'h03, 8'h01, 8'h03, 5'h00}, {5'h01, 8'h03, 8'h03, 5'h00},
      {5'h03, 8'h00, 8'h01, 5'h00}, {5'h03, 8'h01, 8'h01, 5'h01},
      {5'h01, 8'h01, 8'h01, 5'h00}, {5'h00, 8'h03, 8'h01, 5'h00},
      {5'h01, 8'h00, 8'h00, 5'h00}};
endpackage : slm_pkg

/* File: rtl/slm_prog.sv */
`timescale 1ns/100ps
module slm_prog (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   slm_cfg_if.prog bus,
   // user request
   input wire logic start,
   input wire logic [2:0] mode_sel,
   input wire logic scramble_en,
   input wire logic k32_sel,
   input wire logic subclass1,
   input wire logic dual_link_req,
   // user status
   output logic busy,
   output logic done,
   output logic cfg_error,
   output logic mode_bad
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_WRITE = 5'b00010,
      ST_SETTLE = 5'b00100,
      ST_READ = 5'b01000,
      ST_WAIT = 5'b10000
   } slm_state_t;

   slm_state_t st_q, st_d;
   logic [3:0] step_q, step_d;
   logic [11:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d;
   logic wr_q, wr_d, rd_q, rd_d;
   logic busy_d, done_d, err_d, bad_d;
   slm_pkg::slm_mode_t mode_q, mode_d;
   logic [4:0] opts_q, opts_d;
   logic [19:0] word;

   // ----------------------------------------
   // one register write per step
   // ----------------------------------------
   function automatic logic [19:0] step_word(input logic [3:0] s, input slm_pkg::slm_mode_t m, input logic [4:0] o);
      logic [7:0] sub;
      sub = {(o[2] ? slm_pkg::SUBCLASS_1 : slm_pkg::SUBCLASS_0), slm_pkg::SAMPLE_WIDTH_16};
      case (s)
         4'h0: return {slm_pkg::ADDR_LINK_CTRL, 4'h0, o[3], 3'h0};
         4'h1: return {slm_pkg::ADDR_LANE, o[0], 2'h0, m.lanes_m1};
         4'h2: return {slm_pkg::ADDR_OCTETS, m.octets_m1};
         4'h3: return {slm_pkg::ADDR_FRAMES_MF, 3'h0, (o[1] ? slm_pkg::FRAMES_32 : slm_pkg::FRAMES_16)};
         4'h4: return {slm_pkg::ADDR_CONV, m.conv_m1};
         4'h5: return {slm_pkg::ADDR_RES, slm_pkg::RES_VALUE};
         4'h6: return {slm_pkg::ADDR_SUBCLASS, sub};
         4'h7: return {slm_pkg::ADDR_VERSION, slm_pkg::VERSION_B, m.samples_m1};
         4'h8: return {slm_pkg::ADDR_DENSITY, m.high_density, 7'h00};
         4'h9: return {slm_pkg::ADDR_DESKEW, m.lane_mask};
         4'ha: return {slm_pkg::ADDR_OCTETS_DIRECT, 8'(m.octets_m1 + 8'h01)};
         default: return {slm_pkg::ADDR_LANE_EN, m.lane_mask};
      endcase
   endfunction : step_word

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      step_d = step_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      wr_d = 1'b0;
      rd_d = 1'b0;
      busy_d = busy;
      done_d = 1'b0;
      err_d = cfg_error;
      bad_d = mode_bad;
      mode_d = mode_q;
      opts_d = opts_q;
      word = step_word(step_q, mode_q, opts_q);
      case (st_q)
         ST_IDLE: begin
            if (start) begin
               bad_d = 1'b0;
               step_d = 4'h0;
               opts_d = {1'b0, dual_link_req, subclass1, k32_sel, scramble_en};
               busy_d = 1'b1;
               st_d = ST_WRITE;
               case (mode_sel)
                  3'h2: mode_d = slm_pkg::MODE2;
                  3'h3: mode_d = slm_pkg::MODE3;
                  3'h4: mode_d = slm_pkg::MODE4;
                  3'h5: mode_d = slm_pkg::MODE5;
                  default: begin
                     bad_d = 1'b1;
                     busy_d = 1'b0;
                     done_d = 1'b1;
                     st_d = ST_IDLE;
                  end
               endcase
            end
         end
         ST_WRITE: begin
            addr_d = word[19:8];
            wdata_d = word[7:0];
            wr_d = 1'b1;
            step_d = 4'(step_q + 4'h1);
            if (step_q == slm_pkg::PROG_LAST_STEP) begin
               st_d = ST_SETTLE;
            end
         end
         // status is two registers behind the last write
         ST_SETTLE: st_d = ST_READ;
         ST_READ: begin
            addr_d = slm_pkg::ADDR_STATUS;
            rd_d = 1'b1;
            st_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (bus.rvalid) begin
               err_d = bus.rdata[slm_pkg::STATUS_LMFS_BIT];
               busy_d = 1'b0;
               done_d = 1'b1;
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         step_q <= 4'h0;
         addr_q <= 12'h000;
         wdata_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         cfg_error <= 1'b0;
         mode_bad <= 1'b0;
         mode_q <= slm_pkg::MODE2;
         opts_q <= 5'h00;
      end else begin
         st_q <= st_d;
         step_q <= step_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         busy <= busy_d;
         done <= done_d;
         cfg_error <= err_d;
         mode_bad <= bad_d;
         mode_q <= mode_d;
         opts_q <= opts_d;
      end
   end

   assign bus.addr = addr_q;
   assign bus.wdata = wdata_q;
   assign bus.wr = wr_q;
   assign bus.rd = rd_q;
endmodule : slm_prog

/* File: tb/serial_link_mode_config_test.sv */
`timescale 1ns/100ps
module serial_link_mode_config_test;
   // ----------------------------------------
   // signals and expected tables
   // ----------------------------------------
   logic mclk, rst, start, scramble_en, k32_sel, subclass1, dual_link_req;
   logic [2:0] mode_sel, subclass;
   logic busy, done, cfg_error, mode_bad, descramble_en, high_density, dual_link_select, cfg_check, b_check;
   logic [5:0] lane_count, frames_per_mf, samples_per_conv;
   logic [8:0] octets_per_frame, converter_count;
   logic [7:0] deskew_mask, lane_enable;
   int n_errors, n_tests, cycles;
   // mode 2..5 expectations, index is mode minus two
   localparam logic [8:0] EXP_L [4] = '{9'h004, 9'h002, 9'h004, 9'h004};
   localparam logic [8:0] EXP_M [4] = '{9'h004, 9'h004, 9'h002, 9'h002};
   localparam logic [8:0] EXP_F [4] = '{9'h002, 9'h004, 9'h001, 9'h002};
   localparam logic [8:0] EXP_S [4] = '{9'h001, 9'h001, 9'h001, 9'h002};
   localparam logic [8:0] EXP_HD [4] = '{9'h000, 9'h000, 9'h001, 9'h000};
   localparam logic [8:0] EXP_K [4] = '{9'h00f, 9'h003, 9'h00f, 9'h00f};
   // a legal mode 5 map with dual link and the high density bit set, written straight to the second device
   localparam logic [11:0] ADDR_TAB [12] = '{slm_pkg::ADDR_LINK_CTRL, slm_pkg::ADDR_LANE, slm_pkg::ADDR_OCTETS,
      slm_pkg::ADDR_FRAMES_MF, slm_pkg::ADDR_CONV, slm_pkg::ADDR_RES, slm_pkg::ADDR_SUBCLASS,
      slm_pkg::ADDR_VERSION, slm_pkg::ADDR_DENSITY, slm_pkg::ADDR_DESKEW, slm_pkg::ADDR_OCTETS_DIRECT,
      slm_pkg::ADDR_LANE_EN};
   localparam logic [7:0] VAL_TAB [12] = '{8'h08, 8'h83, 8'h01, 8'h1f, 8'h01, 8'h0f, 8'h2f, 8'h21, 8'h80,
      8'h0f, 8'h02, 8'h0f};
   slm_cfg_if cfg();
   slm_cfg_if cfg_b();

   // ----------------------------------------
   // design ends and checker
   // ----------------------------------------
   slm_prog u_slm_prog (.mclk(mclk), .rst(rst), .bus(cfg), .start(start), .mode_sel(mode_sel),
      .scramble_en(scramble_en), .k32_sel(k32_sel), .subclass1(subclass1), .dual_link_req(dual_link_req),
      .busy(busy), .done(done), .cfg_error(cfg_error), .mode_bad(mode_bad));
   slm_dev u_slm_dev (.mclk(mclk), .rst(rst), .bus(cfg), .descramble_en(descramble_en), .lane_count(lane_count),
      .octets_per_frame(octets_per_frame), .frames_per_mf(frames_per_mf), .converter_count(converter_count),
      .subclass(subclass), .samples_per_conv(samples_per_conv), .high_density(high_density),
      .deskew_mask(deskew_mask), .lane_enable(lane_enable), .dual_link_select(dual_link_select),
      .cfg_check(cfg_check));
   // second device on a port driven by the bench, for values the sequencer never writes
   slm_dev u_slm_dev_b (.mclk(mclk), .rst(rst), .bus(cfg_b), .descramble_en(), .lane_count(),
      .octets_per_frame(), .frames_per_mf(), .converter_count(), .subclass(), .samples_per_conv(),
      .high_density(), .deskew_mask(), .lane_enable(), .dual_link_select(), .cfg_check(b_check));
   slm_cfg_checker u_slm_cfg_checker (.mclk(mclk), .rst(rst), .addr(cfg.addr), .wdata(cfg.wdata),
      .wr(cfg.wr), .rd(cfg.rd), .rdata(cfg.rdata), .rvalid(cfg.rvalid), .descramble_en(descramble_en),
      .lane_count(lane_count), .octets_per_frame(octets_per_frame), .converter_count(converter_count));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // strobe lowered then an idle cycle, so no signal is set twice in one step
   task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
      cfg_b.addr = a;
      cfg_b.wdata = d;
      cfg_b.wr = 1'b1;
      @(negedge mclk);
      cfg_b.wr = 1'b0;
      cfg_b.addr = ~a;
      cfg_b.wdata = ~d;
      @(negedge mclk);
   endtask : reg_write

   // the answer stands for one cycle only, so it is taken before the strobe drops
   task automatic reg_read(input logic [11:0] a, input logic [7:0] exp);
      cfg_b.addr = a;
      cfg_b.rd = 1'b1;
      @(negedge mclk);
      chk({8'h00, cfg_b.rvalid}, 9'h001);
      chk({1'b0, cfg_b.rdata}, {1'b0, exp});
      cfg_b.rd = 1'b0;
      cfg_b.addr = ~a;
      @(negedge mclk);
   endtask : reg_read

   task automatic run_mode(input logic [2:0] m, input logic s, input logic k, input logic sc, input logic dl);
      int j;
      j = int'(m) - 2;
      mode_sel = m;
      scramble_en = s;
      k32_sel = k;
      subclass1 = sc;
      dual_link_req = dl;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      chk({8'h00, busy}, {8'h00, m >= 3'h2 && m <= 3'h5});
      for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge mclk);
      chk({8'h00, done}, 9'h001);
      chk({8'h00, busy}, 9'h000);
      if (j >= 0 && j <= 3) begin
         chk({3'h0, lane_count}, EXP_L[j]);
         chk(converter_count, EXP_M[j]);
         chk(octets_per_frame, EXP_F[j]);
         chk({3'h0, samples_per_conv}, EXP_S[j]);
         chk({8'h00, high_density}, EXP_HD[j]);
         chk({1'b0, deskew_mask}, EXP_K[j]);
         chk({1'b0, lane_enable}, EXP_K[j]);
         chk({8'h00, descramble_en}, {8'h00, s});
         chk({3'h0, frames_per_mf}, k ? 9'h020 : 9'h010);
         chk({6'h00, subclass}, {8'h00, sc});
         chk({8'h00, dual_link_select}, {8'h00, dl});
         chk({8'h00, cfg_error}, {8'h00, dl && j < 2});
         chk({8'h00, cfg_check}, {8'h00, dl && j < 2});
      end else begin
         chk({8'h00, mode_bad}, 9'h001);
      end
   endtask : run_mode

   task automatic complete_run();
      if (n_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   // ----------------------------------------
   // clock, watchdog and sequence
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // a hung handshake ends the run as a failure
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 4000) begin
         n_errors++;
         complete_run();
      end
   end

   initial begin
      rst = 1'b1;
      {start, scramble_en, k32_sel, subclass1, dual_link_req, mode_sel} = 8'h00;
      {cfg_b.addr, cfg_b.wdata, cfg_b.wr, cfg_b.rd} = 22'h000000;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      for (int i = 0; i < 12; i++) reg_read(ADDR_TAB[i], 8'h00);
      reg_read(slm_pkg::ADDR_STATUS, 8'h0c);
      chk({8'h00, b_check}, 9'h001);
      for (int i = 0; i < 12; i++) reg_write(ADDR_TAB[i], VAL_TAB[i]);
      for (int i = 0; i < 12; i++) reg_read(ADDR_TAB[i], VAL_TAB[i]);
      reg_write(slm_pkg::ADDR_STATUS, 8'hff);
      reg_write(12'h401, 8'h5a);
      reg_read(12'h401, 8'h00);
      reg_read(slm_pkg::ADDR_STATUS, 8'h00);
      chk({8'h00, b_check}, 9'h000);
      reg_write(slm_pkg::ADDR_OCTETS_DIRECT, 8'h01);
      reg_read(slm_pkg::ADDR_STATUS, 8'h08);
      reg_write(slm_pkg::ADDR_FRAMES_MF, 8'h10);
      reg_read(slm_pkg::ADDR_STATUS, 8'h0c);
      reg_write(slm_pkg::ADDR_SUBCLASS, 8'h4f);
      reg_read(slm_pkg::ADDR_STATUS, 8'h0e);
      for (int m = 2; m <= 5; m++) begin
         run_mode(3'(m), m[0], m[1], ~m[0], 1'b0);
         run_mode(3'(m), ~m[0], ~m[1], m[0], 1'b1);
      end
      run_mode(3'h6, 1'b0, 1'b0, 1'b0, 1'b0);
      complete_run();
   end
endmodule : serial_link_mode_config_test

/* File: tb/slm_cfg_checker.sv */
`timescale 1ns/100ps
module slm_cfg_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   // decoded settings
   input wire logic descramble_en,
   input wire logic [5:0] lane_count,
   input wire logic [8:0] octets_per_frame,
   input wire logic [8:0] converter_count
);
   // ----------------------------------------
   // port checks
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_read_answer: assert property (rd |=> rvalid)
      else $error("read got no answer");
   a_status_read: assert property (rd |-> addr == slm_pkg::ADDR_STATUS)
      else $error("sequencer read a wrong address");
   a_lane_decode: assert property ((wr && addr == slm_pkg::ADDR_LANE) |=> ##1
      (lane_count == 6'($past(wdata, 2) & 8'h1f) + 6'h01) && (descramble_en == ($past(wdata, 2) >= 8'h80)))
      else $error("lane settings not decoded");
   a_octets_decode: assert property ((wr && addr == slm_pkg::ADDR_OCTETS) |=> ##1
      octets_per_frame == {1'b0, $past(wdata, 2)} + 9'h001) else $error("octet count not decoded");
   a_conv_decode: assert property ((wr && addr == slm_pkg::ADDR_CONV) |=> ##1
      converter_count == {1'b0, $past(wdata, 2)} + 9'h001) else $error("converter count not decoded");
   a_frames_value: assert property ((wr && addr == slm_pkg::ADDR_FRAMES_MF) |->
      (wdata == 8'h0f || wdata == 8'h1f)) else $error("bad frames per multiframe written");
   a_res_value: assert property ((wr && addr == slm_pkg::ADDR_RES) |-> wdata == 8'h0f)
      else $error("bad resolution written");
   a_sample_width: assert property ((wr && addr == slm_pkg::ADDR_SUBCLASS) |-> wdata[4:0] == 5'h0f)
      else $error("bad sample width written");
   a_control_words: assert property ((wr && addr == slm_pkg::ADDR_DENSITY) |-> wdata[4:0] == 5'h00)
      else $error("control words per frame not zero");
   a_version_field: assert property ((wr && addr == slm_pkg::ADDR_VERSION) |-> wdata[7:5] == 3'h1)
      else $error("bad version written");
   a_direct_octets: assert property ((wr && addr == slm_pkg::ADDR_OCTETS_DIRECT) |->
      {1'b0, wdata} == octets_per_frame) else $error("direct octet count mismatch");
endmodule : slm_cfg_checker
